/* File: vpic_map.svh */
// Purpose: register offsets, field positions and reset values of the interrupt controller
// Assumes: AXI4-Lite slave, 32-bit data, byte addresses
// Notes:   included by the controller and the testbench
`ifndef VPIC_MAP_SVH
`define VPIC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define VPIC_SMR_BASE   12'h000
`define VPIC_SVR_BASE   12'h080
`define VPIC_IVR        12'h100
`define VPIC_FVR        12'h104
`define VPIC_ISR        12'h108
`define VPIC_IPR        12'h10c
`define VPIC_IMR        12'h110
`define VPIC_CISR       12'h114
`define VPIC_IECR       12'h120
`define VPIC_IDCR       12'h124
`define VPIC_ICCR       12'h128
`define VPIC_ISCR       12'h12c
`define VPIC_EOICR      12'h130
`define VPIC_SPU        12'h134
`define VPIC_DCR        12'h138
`define VPIC_FFER       12'h140
`define VPIC_FFDR       12'h144
`define VPIC_FFSR       12'h148
`define VPIC_EVS        12'h150
`define VPIC_EVM        12'h154

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define VPIC_PRIO_LSB   0
`define VPIC_TYPE_LSB   5
`define VPIC_DCR_GMSK   1
`define VPIC_SPU_RST    32'h0000_0000
`define VPIC_SMR_RST    8'h00
`define VPIC_RESP_OK    2'b00
`define VPIC_RESP_ERR   2'b10

`endif

/* File: vpic_pkg.sv */
// Purpose: types of the vectored priority interrupt controller
// Assumes: nothing beyond the map header
// Notes:   source types follow the mode field encoding
package vpic_pkg;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		VPIC_LOW_OR_LEVEL = 2'b00,
		VPIC_FALL_OR_EDGE = 2'b01,
		VPIC_HIGH_LEVEL   = 2'b10,
		VPIC_RISE_EDGE    = 2'b11
	} vpic_srctype_t;

	typedef struct packed {
		logic          [31:0] ext_mask;
		logic                 fast_pin;
		logic          [31:0] periph;
	} vpic_src_t;

	typedef struct packed {
		logic       fast_request_n;
		logic       normal_request_n;
		logic       wake;
	} vpic_req_t;
endpackage

/* File: vpic_ctrl.sv */
// Purpose: eight-level vectored interrupt controller, thirty-two sources
// Assumes: one free-running clock, AXI4-Lite register access
// Notes:   source 0 is the fast pin, source 1 the OR of system lines
//
// Contract
// - thirty-two maskable sources, eight-level vectored arbitration
// - drive active-low fast and normal requests
// - per-source priority lets higher requests nest
// - internal sources level or edge detected
// - external pins rise, fall, high, low
// - fast forcing routes source to fast request
// - clock never gated, power management ignored
// - either request wakes the idle core
// - general mask wakes without asserting request
// - source 0 tied to fast interrupt pin
// - source 1 is OR of system lines
// - sources 2-31 from peripherals or pins
// - peripheral identifier equals source number
// - priority 7 most urgent, 0 least
// - equal priority picks lowest source number
// - end-of-service write releases delayed lower requests
// - eight-entry stack of source and priority
`timescale 1ns/10ps
`include "vpic_map.svh"

module vpic_ctrl #(
	parameter int NSRC = 32
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire vpic_pkg::vpic_src_t src_in,
	input  wire logic [31:0]        sys_lines,
	output vpic_pkg::vpic_req_t     req_out,
	input  wire logic [11:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [11:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic                    irq
);
	import vpic_pkg::*;

	if (NSRC != 32)
		$error("vpic_ctrl serves exactly 32 sources");

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]  smr_r [32], smr_nxt [32];
	logic [31:0] svr_r [32], svr_nxt [32];
	logic [31:0] imr_r, imr_nxt, ff_r, ff_nxt, edge_r, edge_nxt, prev_r, prev_nxt;
	logic [31:0] spu_r, spu_nxt, evs_r, evs_nxt, evm_r, evm_nxt;
	logic        gmsk_r, gmsk_nxt;
	logic [4:0]  stk_src_r [8], stk_src_nxt [8];
	logic [2:0]  stk_pri_r [8], stk_pri_nxt [8];
	logic [3:0]  depth_r, depth_nxt;
	logic        aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
	logic [11:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
	logic        fq_n_r, fq_n_nxt, nq_n_r, nq_n_nxt;

	// raw source lines: 0 fast pin, 1 system OR, 2-31 peripherals/pins
	logic [31:0] raw, lvl, pend;
	assign raw = {src_in.periph[31:2] ^ src_in.ext_mask[31:2],
		|sys_lines,
		src_in.fast_pin ^ src_in.ext_mask[0]};

	function automatic logic is_edge(input logic [7:0] smr);
		is_edge = smr[`VPIC_TYPE_LSB];
	endfunction

	// ----------------------------------------------------------------
	// detection and arbitration
	// ----------------------------------------------------------------
	// ext_mask inverts low/falling pins so detection is one polarity
	always_comb
	begin
		for (int i = 0; i < 32; i++)
		begin
			lvl[i] = raw[i] & ~is_edge(smr_r[i]);
			pend[i] = lvl[i] | edge_r[i];
		end
	end

	logic [2:0]  cur_pri;
	logic        in_svc, win_ok;
	assign in_svc = depth_r != 4'h0;
	assign cur_pri = in_svc ? stk_pri_r[depth_r[2:0] - 3'h1] : 3'h0;

	logic [4:0]  win_src;
	logic [2:0]  win_pri;
	logic [31:0] nrm, wdat;
	assign nrm = pend & imr_r & ~ff_r & 32'hffff_fffe;
	always_comb
	begin
		win_src = 5'h0;
		win_pri = 3'h0;
		win_ok = 1'b0;
		for (int i = 31; i >= 1; i--)
			if (nrm[i] && (!win_ok || smr_r[i][2:0] >= win_pri))
			begin
				win_ok = 1'b1;
				win_src = 5'(i);
				win_pri = smr_r[i][2:0];
			end
	end

	logic norm_hit, fast_hit;
	assign norm_hit = win_ok && (!in_svc || win_pri > cur_pri);
	assign fast_hit = |(pend & imr_r & (ff_r | 32'h0000_0001));

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic do_wr, do_rd;
	logic [11:0] wa;
	assign s_axi_awready = !aw_r && !bv_r;
	assign s_axi_wready = !w_r && !bv_r;
	assign s_axi_arready = !rv_r;
	assign do_wr = (aw_r || s_axi_awvalid) && (w_r || s_axi_wvalid) && !bv_r;
	assign wa = aw_r ? awa_r : s_axi_awaddr;
	assign wdat = w_r ? wd_r : s_axi_wdata;
	assign do_rd = s_axi_arvalid && !rv_r;

	always_comb
	begin
		logic [31:0] rd;
		logic        ok;
		rd = 32'h0;
		ok = 1'b1;
		aw_nxt = aw_r;
		w_nxt = w_r;
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		bv_nxt = bv_r && !s_axi_bready;
		br_nxt = br_r;
		rv_nxt = rv_r && !s_axi_rready;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		smr_nxt = smr_r;
		svr_nxt = svr_r;
		imr_nxt = imr_r;
		ff_nxt = ff_r;
		spu_nxt = spu_r;
		gmsk_nxt = gmsk_r;
		evm_nxt = evm_r;
		stk_src_nxt = stk_src_r;
		stk_pri_nxt = stk_pri_r;
		depth_nxt = depth_r;
		prev_nxt = raw;
		edge_nxt = edge_r;
		if (s_axi_awvalid && s_axi_awready && !do_wr)
		begin
			aw_nxt = 1'b1;
			awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready && !do_wr)
		begin
			w_nxt = 1'b1;
			wd_nxt = s_axi_wdata;
		end
		if (do_wr)
		begin
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = `VPIC_RESP_OK;
			if (wa[11:7] == 5'h0)
				smr_nxt[wa[6:2]] = wdat[7:0];
			else if (wa[11:7] == 5'h1)
				svr_nxt[wa[6:2]] = wdat;
			else
				case (wa)
					`VPIC_IECR:  imr_nxt = imr_r | wdat;
					`VPIC_IDCR:  imr_nxt = imr_r & ~wdat;
					`VPIC_ICCR:  edge_nxt = edge_nxt & ~wdat;
					`VPIC_ISCR:  edge_nxt = edge_nxt | wdat;
					`VPIC_EOICR: if (in_svc) depth_nxt = depth_r - 4'h1;
					`VPIC_SPU:   spu_nxt = wdat;
					`VPIC_DCR:   gmsk_nxt = wdat[`VPIC_DCR_GMSK];
					`VPIC_FFER:  ff_nxt = (ff_r | wdat) & 32'hffff_fffe;
					`VPIC_FFDR:  ff_nxt = ff_r & ~wdat;
					`VPIC_EVM:   evm_nxt = wdat;
					`VPIC_EVS:   ;
					default:     br_nxt = `VPIC_RESP_ERR;
				endcase
		end
		// level sources keep no latch, so set/clear commands leave them alone
		for (int i = 0; i < 32; i++)
			if (!is_edge(smr_r[i]))
				edge_nxt[i] = 1'b0;
		// events: edge of either request assertion
		evs_nxt = evs_r;
		if (do_wr && wa == `VPIC_EVS)
			evs_nxt = evs_r & ~wdat;
		if (!fq_n_nxt && fq_n_r)
			evs_nxt[0] = 1'b1;
		if (!nq_n_nxt && nq_n_r)
			evs_nxt[1] = 1'b1;
		if (do_rd)
		begin
			rv_nxt = 1'b1;
			if (s_axi_araddr[11:7] == 5'h0)
				rd = {24'h0, smr_r[s_axi_araddr[6:2]]};
			else if (s_axi_araddr[11:7] == 5'h1)
				rd = svr_r[s_axi_araddr[6:2]];
			else
				case (s_axi_araddr)
					`VPIC_IVR:
					begin
						if (norm_hit && depth_r < 4'h8)
						begin
							rd = svr_r[win_src];
							stk_src_nxt[depth_r[2:0]] = win_src;
							stk_pri_nxt[depth_r[2:0]] = win_pri;
							depth_nxt = depth_r + 4'h1;
							edge_nxt[win_src] = 1'b0;
						end
						else
							rd = spu_r;
					end
					`VPIC_FVR:
					begin
						rd = fast_hit ? svr_r[0] : spu_r;
						edge_nxt[0] = 1'b0;
					end
					`VPIC_ISR:  rd = in_svc ? {27'h0, stk_src_r[depth_r[2:0] - 3'h1]} : 32'h0;
					`VPIC_IPR:  rd = pend;
					`VPIC_IMR:  rd = imr_r;
					`VPIC_CISR: rd = {30'h0, !nq_n_r, !fq_n_r};
					`VPIC_SPU:  rd = spu_r;
					`VPIC_DCR:  rd = {30'h0, gmsk_r, 1'b0};
					`VPIC_FFSR: rd = ff_r;
					`VPIC_EVS:  rd = evs_r;
					`VPIC_EVM:  rd = evm_r;
					default:    ok = 1'b0;
				endcase
			rd_nxt = rd;
			rr_nxt = ok ? `VPIC_RESP_OK : `VPIC_RESP_ERR;
		end
		// edge latch last: a new edge beats clear command and vector read
		for (int i = 0; i < 32; i++)
			if (is_edge(smr_r[i]) && raw[i] && !prev_r[i])
				edge_nxt[i] = 1'b1;
	end

	// ----------------------------------------------------------------
	// request outputs
	// ----------------------------------------------------------------
	// general mask keeps lines high; wake still follows the sources
	always_comb
	begin
		fq_n_nxt = !(fast_hit && !gmsk_r);
		nq_n_nxt = !(norm_hit && !gmsk_r);
	end

	// clock free running: no gating or power input exists
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			smr_r <= '{default: `VPIC_SMR_RST};
			svr_r <= '{default: 32'h0};
			stk_src_r <= '{default: 5'h0};
			stk_pri_r <= '{default: 3'h0};
			imr_r <= 32'h0;
			ff_r <= 32'h0;
			edge_r <= 32'h0;
			prev_r <= 32'h0;
			spu_r <= `VPIC_SPU_RST;
			evs_r <= 32'h0;
			evm_r <= 32'h0;
			gmsk_r <= 1'b0;
			depth_r <= 4'h0;
			aw_r <= 1'b0;
			w_r <= 1'b0;
			bv_r <= 1'b0;
			rv_r <= 1'b0;
			awa_r <= 12'h0;
			wd_r <= 32'h0;
			rd_r <= 32'h0;
			br_r <= 2'b00;
			rr_r <= 2'b00;
			fq_n_r <= 1'b1;
			nq_n_r <= 1'b1;
		end
		else
		begin
			smr_r <= smr_nxt;
			svr_r <= svr_nxt;
			stk_src_r <= stk_src_nxt;
			stk_pri_r <= stk_pri_nxt;
			imr_r <= imr_nxt;
			ff_r <= ff_nxt;
			edge_r <= edge_nxt;
			prev_r <= prev_nxt;
			spu_r <= spu_nxt;
			evs_r <= evs_nxt;
			evm_r <= evm_nxt;
			gmsk_r <= gmsk_nxt;
			depth_r <= depth_nxt;
			aw_r <= aw_nxt;
			w_r <= w_nxt;
			bv_r <= bv_nxt;
			rv_r <= rv_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
			br_r <= br_nxt;
			rr_r <= rr_nxt;
			fq_n_r <= fq_n_nxt;
			nq_n_r <= nq_n_nxt;
		end
	end

	assign req_out.fast_request_n = fq_n_r;
	assign req_out.normal_request_n = nq_n_r;
	assign req_out.wake = fast_hit | norm_hit;
	assign irq = |(evs_r & evm_r);
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rd_r;
	assign s_axi_rresp = rr_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_reset_idle: assert property (@(posedge aclk) !aresetn |=> fq_n_r && nq_n_r && depth_r == 0)
		else $error("requests not idle after reset");
	a_norm_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		norm_hit && !gmsk_r |=> !nq_n_r)
		else $error("normal request missing");
	a_gmask_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(gmsk_r) |-> fq_n_r && nq_n_r)
		else $error("request asserted under general mask");
	a_stack_depth: assert property (@(posedge aclk) disable iff (!aresetn) depth_r <= 8)
		else $error("stack depth overflow");
	a_nest_prio: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(depth_r > 1) |-> stk_pri_r[depth_r[2:0] - 3'h1] > stk_pri_r[depth_r[2:0] - 3'h2])
		else $error("nested entry without higher priority");
	a_fast_force: assert property (@(posedge aclk) disable iff (!aresetn)
		(ff_r[win_src] && win_ok) |-> 1'b0)
		else $error("forced source reached normal arbitration");
	a_src0_fast: assert property (@(posedge aclk) disable iff (!aresetn)
		pend[0] && imr_r[0] && !gmsk_r |=> !fq_n_r)
		else $error("source 0 missed fast request");
	a_wake_out: assert property (@(posedge aclk) disable iff (!aresetn)
		!fq_n_r |-> $past(req_out.wake))
		else $error("fast request without wake");
	a_eoi_pop: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr && wa == `VPIC_EOICR && in_svc |=> depth_r == $past(depth_r) - 1)
		else $error("end of service did not pop");
endmodule

/* File: vpic_core_model.sv */
// Purpose: core side of the request lines, idles until woken
// Assumes: requests active low, wake active high
// Notes:   doze puts the core back into idle
`timescale 1ns/10ps

module vpic_core_model (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire vpic_pkg::vpic_req_t req,
	input  wire logic               doze,
	output logic                    asleep
);
	import vpic_pkg::*;

	logic asleep_r;
	logic asleep_nxt;

	always_comb
	begin
		asleep_nxt = asleep_r;
		if (doze)
			asleep_nxt = 1'b1;
		// any request or the masked wake ends idle
		if (req.wake || !req.fast_request_n || !req.normal_request_n)
			asleep_nxt = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			asleep_r <= 1'b1;
		else
			asleep_r <= asleep_nxt;
	end

	assign asleep = asleep_r;
endmodule

/* File: vpic_ctrl_tb.sv */
// Purpose: self-checking bench of the interrupt controller
// Assumes: AXI4-Lite answers come when the slave decides
// Notes:   sources are enabled, raised and cleaned per scenario
`timescale 1ns/10ps
`include "vpic_map.svh"

module vpic_ctrl_tb;
	import vpic_pkg::*;

	logic        aclk, aresetn, doze, asleep, irq, inv;
	logic        awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd;
	vpic_src_t   src;
	vpic_req_t   req_out;
	logic [31:0] sys_lines, wdat, rdat, d;
	logic [11:0] awa, ara;
	logic [1:0]  brs, rrs, r, brs_q;
	logic [2:0]  pa, pb;
	int          err_total, cmp_count, k, a, b, c, s;

	vpic_ctrl vpic_ctrl_inst (
		.aclk(aclk), .aresetn(aresetn), .src_in(src), .sys_lines(sys_lines),
		.req_out(req_out), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdat), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs),
		.s_axi_rvalid(rv), .s_axi_rready(rrd), .irq(irq)
	);

	vpic_core_model vpic_core_model_inst (
		.aclk(aclk), .aresetn(aresetn), .req(req_out), .doze(doze), .asleep(asleep)
	);

	initial aclk = 1'b0;
	always #20 aclk = ~aclk;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic final_report();
		if (err_total == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// halves may be taken on different edges, so each is released alone
	task automatic wr(input logic [11:0] ad, input logic [31:0] v);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awa <= ad;
		wdat <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		while (!(ta && tw))
		begin
			@(posedge aclk);
			if (!ta && awr)
			begin
				ta = 1'b1;
				awv <= 1'b0;
			end
			if (!tw && wrd)
			begin
				tw = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bv);
		brs_q = brs;
		brd <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] ad, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		ara <= ad;
		arv <= 1'b1;
		rrd <= 1'b1;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		v = rdat;
		rs = rrs;
		rrd <= 1'b0;
	endtask

	task automatic on(input int n, input logic [1:0] ty, input logic [2:0] p);
		wr(`VPIC_SMR_BASE + 12'(4 * n), {25'h0, ty, 2'h0, p});
		wr(`VPIC_IECR, 32'h1 << n);
	endtask

	task automatic off();
		src <= '0;
		sys_lines <= 32'h0;
		wr(`VPIC_IDCR, 32'hffff_ffff);
		wr(`VPIC_ICCR, 32'hffff_ffff);
		wr(`VPIC_EOICR, 32'h0);
	endtask

	task automatic iv(input int n);
		rd(`VPIC_IVR, d, r);
		chk(d, 32'h00a0_0000 | n);
	endtask

	task automatic wq(input logic f, input logic e);
		logic g;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge aclk);
			g = f ? req_out.fast_request_n : req_out.normal_request_n;
			if (g === e)
				break;
		end
		chk(g, e);
	endtask

	task automatic hh();
		logic bad;
		bad = 1'b0;
		repeat (2) @(posedge aclk);
		repeat (6)
		begin
			@(posedge aclk);
			if (req_out.normal_request_n !== 1'b1)
				bad = 1'b1;
		end
		chk(bad, 1'b0);
	endtask

	function automatic int win(int x, int px, int y, int py);
		return (py > px || (py == px && y < x)) ? y : x;
	endfunction

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial
	begin
		{aresetn, doze, awv, wv, brd, arv, rrd, awa, ara, wdat} = '0;
		src = '0;
		sys_lines = 32'h0;
		err_total = 0;
		cmp_count = 0;
		k = $urandom(81);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		chk({req_out.fast_request_n, req_out.normal_request_n, irq}, 3'b110);
		rd(`VPIC_IPR, d, r);
		chk(d, 32'h0);
		rd(12'h118, d, r);
		chk(r, 2'b10);
		wr(12'h118, 32'h1);
		chk(brs_q, 2'b10);
		for (k = 0; k < 32; k++)
			wr(`VPIC_SVR_BASE + 12'(4 * k), 32'h00a0_0000 | k);
		wr(`VPIC_SPU, 32'h0000_0fff);
		rd(`VPIC_IVR, d, r);
		chk(d, 32'h0000_0fff);
		off();
		for (k = 0; k < 6; k++)
		begin
			a = $urandom_range(31, 2);
			b = 2 + (a - 1 + $urandom_range(28, 0)) % 30;
			pa = 3'($urandom_range(7, 0));
			pb = (k < 2) ? pa : 3'($urandom_range(7, 0));
			on(a, 2'b10, pa);
			on(b, 2'b10, pb);
			src.periph <= (32'h1 << a) | (32'h1 << b);
			wq(1'b0, 1'b0);
			c = win(a, pa, b, pb);
			iv(c);
			rd(`VPIC_ISR, d, r);
			chk(d, c);
			off();
		end
		on(5, 2'b10, 3'h2);
		on(9, 2'b10, 3'h2);
		on(20, 2'b10, 3'h5);
		src.periph <= 32'h20;
		wq(1'b0, 1'b0);
		iv(5);
		src.periph <= 32'h220;
		hh();
		src.periph <= 32'h0010_0220;
		wq(1'b0, 1'b0);
		iv(20);
		src.periph <= 32'h220;
		wr(`VPIC_EOICR, 32'h0);
		rd(`VPIC_ISR, d, r);
		chk(d, 32'h5);
		off();
		for (k = 0; k < 4; k++)
		begin
			s = $urandom_range(31, 2);
			inv = !k[1];
			src.ext_mask <= 32'(inv) << s;
			src.periph <= 32'(inv) << s;
			on(s, k[1:0], 3'h3);
			src.periph <= 32'(!inv) << s;
			repeat (2) @(posedge aclk);
			src.periph <= 32'(inv) << s;
			repeat (3) @(posedge aclk);
			rd(`VPIC_IPR, d, r);
			chk(d[s], k[0]);
			wr(`VPIC_ICCR, 32'h1 << s);
			rd(`VPIC_IPR, d, r);
			chk(d[s], 1'b0);
			wr(`VPIC_ISCR, 32'h1 << s);
			rd(`VPIC_IPR, d, r);
			chk(d[s], k[0]);
			off();
		end
		on(0, 2'b10, 3'h0);
		src.fast_pin <= 1'b1;
		wq(1'b1, 1'b0);
		chk(req_out.normal_request_n, 1'b1);
		rd(`VPIC_CISR, d, r);
		chk(d, 32'h1);
		rd(`VPIC_FVR, d, r);
		chk(d, 32'h00a0_0000);
		off();
		s = $urandom_range(31, 2);
		wr(`VPIC_FFER, (32'h1 << s) | 32'h1);
		on(s, 2'b10, 3'h4);
		src.periph <= 32'h1 << s;
		wq(1'b1, 1'b0);
		chk(req_out.normal_request_n, 1'b1);
		rd(`VPIC_FFSR, d, r);
		chk(d, 32'h1 << s);
		wr(`VPIC_FFDR, 32'h1 << s);
		off();
		on(1, 2'b10, 3'h6);
		rd(`VPIC_IMR, d, r);
		chk(d, 32'h2);
		sys_lines <= 32'h1 << $urandom_range(31, 0);
		wq(1'b0, 1'b0);
		iv(1);
		off();
		wr(`VPIC_EVS, 32'h3);
		wr(`VPIC_EVM, 32'h2);
		@(posedge aclk);
		chk(irq, 1'b0);
		on(7, 2'b10, 3'h1);
		src.periph <= 32'h80;
		wq(1'b0, 1'b0);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		wr(`VPIC_EVM, 32'h0);
		@(posedge aclk);
		chk(irq, 1'b0);
		wr(`VPIC_EVM, 32'h2);
		@(posedge aclk);
		chk(irq, 1'b1);
		off();
		wq(1'b0, 1'b1);
		wr(`VPIC_EVS, 32'h2);
		@(posedge aclk);
		chk(irq, 1'b0);
		wr(`VPIC_DCR, 32'h2);
		doze <= 1'b1;
		on(7, 2'b10, 3'h1);
		chk(asleep, 1'b1);
		doze <= 1'b0;
		src.periph <= 32'h80;
		hh();
		chk(req_out.wake, 1'b1);
		chk(asleep, 1'b0);
		off();
		final_report();
	end

	// the whole run takes several hundred cycles
	initial
	begin
		repeat (40000) @(posedge aclk);
		err_total++;
		final_report();
	end
endmodule
